/* include/mce_pkg.sv */
// constants and types shared by the measurement command engine
// Contract
// - one-shot acquire applies function, range, resolution, measures once, result to output
// - setup-only command loads function, range, resolution; no measurement until armed
// - arm-and-return moves idle to wait-for-trigger; trigger then starts measurement
// - arm-and-return readings go to output; measuring halts while output buffer full
// - arm-to-memory moves idle to wait-for-trigger; readings stored in reading memory
// - memory-to-output copies stored readings into the output buffer
// - integration cycles accept 0.02, 0.1, 1, 10 plus minimum and maximum keywords
// - averaging window type is sliding or block-repeat, sliding after reset
// - at most one of seven math operations enabled; new selection replaces old
// - math path stays inactive for continuity and diode functions
// - math preset registers writable by controller; result registers hold outputs
// - math selector offers seven named choices plus separate on/off enable
// - triggers accepted only in wait-for-trigger; others start nothing
// - trigger source is bus software, immediate internal, or external rear panel
// - arm-to-memory while measuring is ignored and logs error -214
// - memory-to-output with empty reading memory logs error -230
package mce_pkg;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int MEM_DEPTH = 16;
  localparam logic [2:0] CMD_ACQUIRE = 3'h1;
  localparam logic [2:0] CMD_SETUP = 3'h2;
  localparam logic [2:0] CMD_ARM_OUT = 3'h3;
  localparam logic [2:0] CMD_ARM_MEM = 3'h4;
  localparam logic [2:0] CMD_MEM_OUT = 3'h5;
  localparam logic [3:0] FUNC_CONT = 4'h9;
  localparam logic [3:0] FUNC_DIODE = 4'ha;
  localparam logic [3:0] FUNC_RESET = 4'h0;
  localparam logic [3:0] RANGE_DEFAULT = 4'hf;
  localparam logic [3:0] RANGE_RESET = 4'h0;
  localparam logic [3:0] RES_DEFAULT = 4'hf;
  localparam logic [3:0] RES_RESET = 4'h0;
  // integration codes: 0.02, 0.1, 1, 10 cycles, then min and max keywords
  localparam logic [2:0] NPL_002 = 3'h0;
  localparam logic [2:0] NPL_01 = 3'h1;
  localparam logic [2:0] NPL_1 = 3'h2;
  localparam logic [2:0] NPL_10 = 3'h3;
  localparam logic [2:0] NPL_MIN = 3'h4;
  localparam logic [2:0] NPL_MAX = 3'h5;
  localparam logic [2:0] NPL_RESET = NPL_10;
  localparam logic [1:0] TRIG_BUS = 2'h0;
  localparam logic [1:0] TRIG_IMM = 2'h1;
  localparam logic [1:0] TRIG_EXT = 2'h2;
  localparam logic [2:0] MATH_PCT = 3'h0;
  localparam logic [2:0] MATH_STATS = 3'h1;
  localparam logic [2:0] MATH_NULL = 3'h2;
  localparam logic [2:0] MATH_LIMIT = 3'h3;
  localparam logic [2:0] MATH_SCALE = 3'h4;
  localparam logic [2:0] MATH_REL_DECIBEL = 3'h5;
  localparam logic [2:0] MATH_ABS_DECIBEL = 3'h6;
  localparam logic [15:0] ERR_INIT_IGNORED = 16'hff2a;
  localparam logic [15:0] ERR_DATA_STALE = 16'hff1a;
  typedef enum logic [2:0] {
    MCE_IDLE, MCE_WAIT_TRIG, MCE_ONE_SHOT_ACQUIRE, MCE_DRAIN
  } mce_state_t;
endpackage

/* hdl/mce_fifo.sv */
// parameterised valid/ready fifo on the reading output path
`timescale 1ns/1ps
`default_nettype none
module mce_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] cnt_reg;
  logic push, pop;
  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        mem[wr_reg] <= in_data;
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* hdl/mce_engine.sv */
// measurement command engine: configuration, trigger machine, reading paths
`timescale 1ns/1ps
`default_nettype none
module mce_engine #(
  parameter int DATA_W = mce_pkg::DATA_W,
  parameter int FIFO_DEPTH = mce_pkg::FIFO_DEPTH,
  parameter int MEM_DEPTH = mce_pkg::MEM_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [3:0] cmd_function,
  input wire logic [3:0] cmd_range,
  input wire logic [3:0] cmd_resolution,
  input wire logic [7:0] cmd_count,
  input wire logic cfg_valid,
  input wire logic [2:0] cfg_integration_cycles,
  input wire logic cfg_average_window_type,
  input wire logic [1:0] cfg_trig_source,
  input wire logic [2:0] cfg_math_op_select,
  input wire logic cfg_math_on,
  input wire logic preset_valid,
  input wire logic [DATA_W-1:0] preset_value,
  input wire logic bus_trigger,
  input wire logic ext_trigger,
  output logic meas_start,
  output logic [3:0] meas_function,
  output logic [3:0] meas_range,
  output logic [3:0] meas_resolution,
  output logic [2:0] integration_cycles,
  output logic average_window_type,
  output logic [2:0] math_op_select,
  output logic math_active,
  input wire logic adc_done,
  input wire logic [DATA_W-1:0] adc_data,
  output logic [DATA_W-1:0] math_result,
  output logic [DATA_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic busy,
  output logic mem_empty,
  output logic err_valid,
  output logic [15:0] err_code
);
  localparam int MAW = $clog2(MEM_DEPTH);
  typedef struct packed {
    mce_pkg::mce_state_t st;
    logic to_mem;
    logic [7:0] left;
    logic [3:0] func;
    logic [3:0] rng;
    logic [3:0] res;
    logic [2:0] npl;
    logic avg;
    logic [1:0] tsrc;
    logic [2:0] mop;
    logic mon;
    logic [DATA_W-1:0] preset;
    logic [DATA_W-1:0] result;
    logic start;
    logic [DATA_W-1:0] pend;
    logic pend_v;
    logic [MAW:0] mcnt;
    logic [MAW-1:0] rdp;
    logic ev;
    logic [15:0] ec;
    logic [DATA_W-1:0] odata;
    logic ovalid;
    logic mact;
    logic bsy;
    logic memp;
  } mce_s_t;
  mce_s_t s_reg, s_next;
  logic [DATA_W-1:0] rmem [MEM_DEPTH];
  logic fifo_in_ready, trig_ok, math_en, wr_mem, push, fifo_pop;
  logic [DATA_W-1:0] fifo_q;
  logic fifo_v;

  function automatic logic math_allowed(input logic [3:0] f);
    math_allowed = (f != mce_pkg::FUNC_CONT) && (f != mce_pkg::FUNC_DIODE);
  endfunction

  always_comb begin
    unique case (s_reg.tsrc)
      mce_pkg::TRIG_BUS: trig_ok = bus_trigger;
      mce_pkg::TRIG_EXT: trig_ok = ext_trigger;
      default: trig_ok = 1'b1;
    endcase
  end
  assign math_en = s_reg.mon && math_allowed(s_reg.func);
  assign push = s_reg.pend_v && fifo_in_ready;
  assign wr_mem = adc_done && s_reg.st == mce_pkg::MCE_ONE_SHOT_ACQUIRE && s_reg.to_mem
                  && s_reg.mcnt != (MAW+1)'(MEM_DEPTH);

  always_comb begin
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.ev = 1'b0;
    if (push) s_next.pend_v = 1'b0;
    if (cfg_valid) begin
      if (cfg_integration_cycles <= mce_pkg::NPL_MAX) s_next.npl = cfg_integration_cycles;
      s_next.avg = cfg_average_window_type;
      s_next.tsrc = cfg_trig_source;
      if (cfg_math_op_select <= mce_pkg::MATH_ABS_DECIBEL) s_next.mop = cfg_math_op_select;
      s_next.mon = cfg_math_on;
    end
    if (preset_valid) s_next.preset = preset_value;
    unique case (s_reg.st)
      mce_pkg::MCE_IDLE: begin
        if (cmd_valid) begin
          if (cmd_code == mce_pkg::CMD_ACQUIRE || cmd_code == mce_pkg::CMD_SETUP) begin
            s_next.func = cmd_function;
            s_next.rng = (cmd_range == mce_pkg::RANGE_DEFAULT) ? mce_pkg::RANGE_RESET
                         : cmd_range;
            s_next.res = (cmd_resolution == mce_pkg::RES_DEFAULT) ? mce_pkg::RES_RESET
                         : cmd_resolution;
          end
          if (cmd_code == mce_pkg::CMD_ACQUIRE) begin
            s_next.npl = mce_pkg::NPL_RESET;
            s_next.tsrc = mce_pkg::TRIG_IMM;
            s_next.mon = 1'b0;
            s_next.to_mem = 1'b0;
            s_next.left = 8'h01;
            s_next.st = mce_pkg::MCE_WAIT_TRIG;
          end
          if (cmd_code == mce_pkg::CMD_ARM_OUT || cmd_code == mce_pkg::CMD_ARM_MEM) begin
            s_next.to_mem = cmd_code == mce_pkg::CMD_ARM_MEM;
            s_next.left = (cmd_count == 8'h00) ? 8'h01 : cmd_count;
            s_next.st = mce_pkg::MCE_WAIT_TRIG;
            if (cmd_code == mce_pkg::CMD_ARM_MEM) s_next.mcnt = '0;
          end
          if (cmd_code == mce_pkg::CMD_MEM_OUT) begin
            if (s_reg.mcnt == '0) begin
              s_next.ev = 1'b1;
              s_next.ec = mce_pkg::ERR_DATA_STALE;
            end else begin
              s_next.rdp = '0;
              s_next.st = mce_pkg::MCE_DRAIN;
            end
          end
        end
      end
      mce_pkg::MCE_WAIT_TRIG: begin
        // pending reading must leave before the next is started
        if (trig_ok && !s_reg.pend_v) begin
          s_next.start = 1'b1;
          s_next.st = mce_pkg::MCE_ONE_SHOT_ACQUIRE;
        end
      end
      mce_pkg::MCE_ONE_SHOT_ACQUIRE: begin
        if (adc_done) begin
          s_next.result = math_en ? adc_data - s_reg.preset : adc_data;
          if (!s_reg.to_mem) begin
            s_next.pend = adc_data;
            s_next.pend_v = 1'b1;
          end else if (wr_mem) begin
            s_next.mcnt = s_reg.mcnt + 1'b1;
          end
          s_next.left = s_reg.left - 8'h01;
          s_next.st = (s_reg.left == 8'h01) ? mce_pkg::MCE_IDLE
                      : mce_pkg::MCE_WAIT_TRIG;
        end
      end
      mce_pkg::MCE_DRAIN: begin
        if (!s_reg.pend_v || push) begin
          s_next.pend = rmem[s_reg.rdp];
          s_next.pend_v = 1'b1;
          s_next.rdp = s_reg.rdp + 1'b1;
          if ((MAW+1)'(s_reg.rdp) + 1'b1 == s_reg.mcnt) s_next.st = mce_pkg::MCE_IDLE;
        end
      end
      default: s_next.st = mce_pkg::MCE_IDLE;
    endcase
    if (cmd_valid && cmd_code == mce_pkg::CMD_ARM_MEM && s_reg.st != mce_pkg::MCE_IDLE) begin
      s_next.ev = 1'b1;
      s_next.ec = mce_pkg::ERR_INIT_IGNORED;
    end
    // an offered reading is held until the controller takes it
    if (fifo_pop) begin
      s_next.odata = fifo_q;
      s_next.ovalid = fifo_v;
    end
    s_next.mact = s_next.mon && math_allowed(s_next.func);
    s_next.bsy = s_next.st != mce_pkg::MCE_IDLE;
    s_next.memp = s_next.mcnt == '0;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= mce_pkg::MCE_IDLE;
      s_reg.func <= mce_pkg::FUNC_RESET;
      s_reg.npl <= mce_pkg::NPL_RESET;
      s_reg.avg <= 1'b0;
      s_reg.tsrc <= mce_pkg::TRIG_IMM;
      s_reg.mop <= mce_pkg::MATH_PCT;
      s_reg.memp <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
    if (wr_mem) rmem[s_reg.mcnt[MAW-1:0]] <= adc_data;
  end

  // fifo output is re-registered; a pop only happens while the register is empty or taken
  assign fifo_pop = !s_reg.ovalid || out_ready;
  mce_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_data(s_reg.pend),
    .in_valid(s_reg.pend_v),
    .in_ready(fifo_in_ready),
    .out_data(fifo_q),
    .out_valid(fifo_v),
    .out_ready(fifo_pop)
  );

  assign meas_start = s_reg.start;
  assign meas_function = s_reg.func;
  assign meas_range = s_reg.rng;
  assign meas_resolution = s_reg.res;
  assign integration_cycles = s_reg.npl;
  assign average_window_type = s_reg.avg;
  assign math_op_select = s_reg.mop;
  assign math_active = s_reg.mact;
  assign math_result = s_reg.result;
  assign out_data = s_reg.odata;
  assign out_valid = s_reg.ovalid;
  assign busy = s_reg.bsy;
  assign mem_empty = s_reg.memp;
  assign err_valid = s_reg.ev;
  assign err_code = s_reg.ec;

  sequence arm_seq;
    s_reg.st == mce_pkg::MCE_IDLE && cmd_valid &&
    (cmd_code == mce_pkg::CMD_ARM_OUT || cmd_code == mce_pkg::CMD_ARM_MEM);
  endsequence
  a_arm_to_wait: assert property (@(posedge clock) disable iff (rst)
    arm_seq |=> s_reg.st == mce_pkg::MCE_WAIT_TRIG)
    else $error("arm did not enter wait-for-trigger");
  a_trig_only_wait: assert property (@(posedge clock) disable iff (rst)
    s_next.start |-> s_reg.st == mce_pkg::MCE_WAIT_TRIG && trig_ok)
    else $error("measurement started outside wait-for-trigger");
  a_busy_arm_error: assert property (@(posedge clock) disable iff (rst)
    cmd_valid && cmd_code == mce_pkg::CMD_ARM_MEM && busy
    |=> err_valid && err_code == mce_pkg::ERR_INIT_IGNORED)
    else $error("busy arm-to-memory not flagged");
  a_stale_fetch_error: assert property (@(posedge clock) disable iff (rst)
    !busy && cmd_valid && cmd_code == mce_pkg::CMD_MEM_OUT && mem_empty
    |=> err_valid && err_code == mce_pkg::ERR_DATA_STALE && !busy)
    else $error("empty fetch not flagged");
  a_math_off_cont: assert property (@(posedge clock) disable iff (rst)
    (meas_function == mce_pkg::FUNC_CONT || meas_function == mce_pkg::FUNC_DIODE)
    |-> !math_active)
    else $error("math active for continuity or diode");
  a_last_to_idle: assert property (@(posedge clock) disable iff (rst)
    s_reg.st == mce_pkg::MCE_ONE_SHOT_ACQUIRE && adc_done && s_reg.left == 8'h01 |=> !busy)
    else $error("engine did not return to idle");
  a_full_stalls: assert property (@(posedge clock) disable iff (rst)
    s_reg.pend_v && !fifo_in_ready |=> !meas_start)
    else $error("measuring continued with output full");
  a_mem_write: assert property (@(posedge clock) disable iff (rst)
    wr_mem |=> !mem_empty && s_reg.mcnt == $past(s_reg.mcnt) + 1'b1)
    else $error("reading not stored in memory");
  a_reset_sliding: assert property (@(posedge clock)
    rst |=> !average_window_type)
    else $error("window type not sliding after reset");
endmodule
`default_nettype wire

/* sim/mce_ctrl_model.sv */
// bus controller model: drains the reading stream at an uneven pace, can stall
`timescale 1ns/1ps
`default_nettype none
module mce_ctrl_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic stall,
  input wire logic [31:0] out_data,
  input wire logic out_valid,
  output logic out_ready,
  output logic got,
  output logic [31:0] got_data
);
  logic [4:0] pace_reg;
  // no kinder than a real controller: ready drops on some cycles even when not stalled
  always_ff @(posedge clock) begin
    if (rst) begin
      pace_reg <= 5'h15;
      out_ready <= 1'b0;
      got <= 1'b0;
      got_data <= 32'h0000_0000;
    end else begin
      pace_reg <= {pace_reg[3:0], pace_reg[4] ^ pace_reg[2]};
      out_ready <= !stall && (pace_reg[0] || pace_reg[3]);
      got <= out_valid && out_ready;
      got_data <= out_data;
    end
  end
endmodule
`default_nettype wire

/* sim/meter_measurement_command_engine_bench.sv */
// self-checking bench of the measurement command engine
`timescale 1ns/1ps
`default_nettype none
module meter_measurement_command_engine_bench;
  logic clock, rst, cmd_valid, cfg_valid, cfg_average_window_type, cfg_math_on, preset_valid;
  logic bus_trigger, ext_trigger, adc_done, out_ready, stall, got, meas_start, out_valid;
  logic math_active, busy, mem_empty, err_valid, average_window_type;
  logic [2:0] cmd_code, cfg_integration_cycles, cfg_math_op_select, integration_cycles;
  logic [2:0] math_op_select;
  logic [3:0] cmd_function, cmd_range, cmd_resolution, meas_function, meas_range, meas_resolution;
  logic [7:0] cmd_count;
  logic [1:0] cfg_trig_source;
  logic [31:0] preset_value, adc_data, out_data, got_data, math_result, seed, last_rd;
  logic [15:0] err_code;
  logic [31:0] exp_q[$], mem_q[$], err_q[$];
  int miscompares, checks, starts, i;
  bit tomem;
  mce_engine u_mce_engine (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_function(cmd_function), .cmd_range(cmd_range), .cmd_resolution(cmd_resolution),
    .cmd_count(cmd_count), .cfg_valid(cfg_valid), .cfg_integration_cycles(cfg_integration_cycles),
    .cfg_average_window_type(cfg_average_window_type), .cfg_trig_source(cfg_trig_source),
    .cfg_math_op_select(cfg_math_op_select), .cfg_math_on(cfg_math_on),
    .preset_valid(preset_valid), .preset_value(preset_value), .bus_trigger(bus_trigger),
    .ext_trigger(ext_trigger), .meas_start(meas_start), .meas_function(meas_function),
    .meas_range(meas_range), .meas_resolution(meas_resolution),
    .integration_cycles(integration_cycles), .average_window_type(average_window_type),
    .math_op_select(math_op_select), .math_active(math_active), .adc_done(adc_done),
    .adc_data(adc_data), .math_result(math_result), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready), .busy(busy), .mem_empty(mem_empty),
    .err_valid(err_valid), .err_code(err_code));
  mce_ctrl_model u_mce_ctrl_model (.clock(clock), .rst(rst), .stall(stall),
    .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready), .got(got),
    .got_data(got_data));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (exp !== seen) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [3:0] f, input logic [3:0] r,
                     input logic [3:0] s, input logic [7:0] n);
    @(negedge clock);
    {cmd_valid, cmd_code, cmd_function, cmd_range, cmd_resolution, cmd_count} = {1'b1, c, f, r, s, n};
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask
  task automatic cfg(input logic [2:0] ic, input logic wt, input logic [1:0] ts,
                     input logic [2:0] mo, input logic on);
    @(negedge clock);
    {cfg_valid, cfg_integration_cycles, cfg_average_window_type} = {1'b1, ic, wt};
    {cfg_trig_source, cfg_math_op_select, cfg_math_on} = {ts, mo, on};
    @(negedge clock);
    cfg_valid = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge clock);
    chk("busy", 32'h0, {31'h0, busy});
    repeat (3) @(negedge clock);
  endtask
  task automatic pulse_trig(input bit ext);
    @(negedge clock);
    if (ext) ext_trigger = 1'b1;
    else bus_trigger = 1'b1;
    @(negedge clock);
    {bus_trigger, ext_trigger} = 2'b00;
  endtask
  // front end: answers every conversion start with a fresh reading
  always @(negedge clock) begin
    if (meas_start === 1'b1) begin
      starts++;
      repeat (2) @(negedge clock);
      adc_data = rnd();
      last_rd = adc_data;
      adc_done = 1'b1;
      if (tomem) mem_q.push_back(adc_data);
      else exp_q.push_back(adc_data);
      @(negedge clock);
      adc_done = 1'b0;
    end
  end
  always @(posedge clock) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected reading", 32'h0, 32'h1);
      else chk("out_data", exp_q.pop_front(), got_data);
    end
    if (err_valid === 1'b1) begin
      if (err_q.size() == 0) chk("unexpected error", 32'h0, 32'h1);
      else chk("err_code", err_q.pop_front(), {16'h0000, err_code});
    end
  end
  initial begin
    #400us;
    miscompares++;
    end_of_test();
  end
  initial begin
    {rst, cmd_valid, cfg_valid, preset_valid, bus_trigger, ext_trigger, adc_done, stall} = 8'h81;
    {cmd_code, cmd_function, cmd_range, cmd_resolution, cmd_count} = 23'h0;
    {cfg_integration_cycles, cfg_average_window_type, cfg_trig_source} = 6'h0;
    {cfg_math_op_select, cfg_math_on, preset_value, adc_data} = 68'h0;
    {miscompares, checks, starts, tomem, seed} = {32'h0, 32'h0, 32'h0, 1'b0, 32'h0000_9cfe};
    repeat (5) @(posedge clock);
    @(negedge clock);
    {rst, stall} = 2'b00;
    chk("integration_cycles", {29'h0, mce_pkg::NPL_RESET}, {29'h0, integration_cycles});
    chk("average_window_type", 32'h0, {31'h0, average_window_type});
    err_q.push_back({16'h0000, mce_pkg::ERR_DATA_STALE});
    cmd(mce_pkg::CMD_MEM_OUT, 4'h0, 4'h0, 4'h0, 8'h00);
    for (i = 0; i < 7; i++) begin
      cfg(i[2:0], 1'b0, mce_pkg::TRIG_IMM, 3'h0, 1'b0);
      chk("integration_cycles", (i < 6) ? i : 5, {29'h0, integration_cycles});
    end
    for (i = 0; i < 8; i++) begin
      cfg(mce_pkg::NPL_10, i[0], mce_pkg::TRIG_IMM, i[2:0], 1'b0);
      chk("math_op_select", (i < 7) ? i : 6, {29'h0, math_op_select});
      chk("average_window_type", i[0], {31'h0, average_window_type});
    end
    cfg(mce_pkg::NPL_10, 1'b0, mce_pkg::TRIG_EXT, mce_pkg::MATH_NULL, 1'b1);
    pulse_trig(1'b1);
    pulse_trig(1'b0);
    repeat (5) @(negedge clock);
    chk("starts outside wait", 32'h0, starts);
    cmd(mce_pkg::CMD_SETUP, 4'h3, mce_pkg::RANGE_DEFAULT, mce_pkg::RES_DEFAULT, 8'h00);
    repeat (5) @(negedge clock);
    chk("meas_function", 32'h3, {28'h0, meas_function});
    chk("meas_range", {28'h0, mce_pkg::RANGE_RESET}, {28'h0, meas_range});
    chk("meas_resolution", {28'h0, mce_pkg::RES_RESET}, {28'h0, meas_resolution});
    chk("starts after setup", 32'h0, starts);
    chk("math_active", 32'h1, {31'h0, math_active});
    @(negedge clock);
    {preset_valid, preset_value} = {1'b1, rnd()};
    @(negedge clock);
    preset_valid = 1'b0;
    for (i = 0; i < 2; i++) begin
      cmd(mce_pkg::CMD_SETUP, i ? mce_pkg::FUNC_DIODE : mce_pkg::FUNC_CONT, 4'h1, 4'h1, 8'h00);
      repeat (3) @(negedge clock);
      chk("math_active", 32'h0, {31'h0, math_active});
    end
    cmd(mce_pkg::CMD_SETUP, 4'h1, 4'h2, 4'h2, 8'h00);
    for (i = 0; i < 2; i++) begin
      cfg(mce_pkg::NPL_1, 1'b0, i ? mce_pkg::TRIG_EXT : mce_pkg::TRIG_BUS, 3'h0, i[0]);
      cmd(mce_pkg::CMD_ARM_OUT, 4'h1, 4'h2, 4'h2, 8'h00);
      repeat (4) @(negedge clock);
      chk("busy waiting", 32'h1, {31'h0, busy});
      chk("starts before trigger", i, starts);
      pulse_trig(i[0]);
      wait_idle();
      chk("starts after trigger", i + 1, starts);
      chk("math_result", i ? last_rd - preset_value : last_rd, math_result);
    end
    cfg(mce_pkg::NPL_1, 1'b0, mce_pkg::TRIG_IMM, 3'h0, 1'b0);
    stall = 1'b1;
    cmd(mce_pkg::CMD_ARM_OUT, 4'h1, 4'h2, 4'h2, 8'h0b);
    repeat (300) @(negedge clock);
    chk("busy while output full", 32'h1, {31'h0, busy});
    stall = 1'b0;
    wait_idle();
    tomem = 1'b1;
    cfg(mce_pkg::NPL_1, 1'b0, mce_pkg::TRIG_EXT, 3'h0, 1'b0);
    cmd(mce_pkg::CMD_ARM_MEM, 4'h1, 4'h2, 4'h2, 8'h00);
    err_q.push_back({16'h0000, mce_pkg::ERR_INIT_IGNORED});
    cmd(mce_pkg::CMD_ARM_MEM, 4'h1, 4'h2, 4'h2, 8'h00);
    pulse_trig(1'b1);
    wait_idle();
    chk("mem_empty", 32'h0, {31'h0, mem_empty});
    cfg(mce_pkg::NPL_1, 1'b0, mce_pkg::TRIG_IMM, 3'h0, 1'b0);
    // a fresh arm-to-memory starts the reading memory over
    mem_q.delete();
    cmd(mce_pkg::CMD_ARM_MEM, 4'h1, 4'h2, 4'h2, 8'h02);
    wait_idle();
    chk("mem_empty", 32'h0, {31'h0, mem_empty});
    chk("stored readings", 32'h2, mem_q.size());
    tomem = 1'b0;
    while (mem_q.size() > 0) exp_q.push_back(mem_q.pop_front());
    cmd(mce_pkg::CMD_MEM_OUT, 4'h0, 4'h0, 4'h0, 8'h00);
    repeat (60) @(negedge clock);
    cmd(mce_pkg::CMD_ACQUIRE, 4'h2, 4'h5, 4'h6, 8'h00);
    wait_idle();
    chk("meas_function", 32'h2, {28'h0, meas_function});
    chk("meas_range", 32'h5, {28'h0, meas_range});
    chk("meas_resolution", 32'h6, {28'h0, meas_resolution});
    chk("integration_cycles", {29'h0, mce_pkg::NPL_RESET}, {29'h0, integration_cycles});
    for (i = 0; i < 200 && exp_q.size() > 0; i++) @(negedge clock);
    chk("readings left", 32'h0, exp_q.size());
    chk("errors left", 32'h0, err_q.size());
    end_of_test();
  end
endmodule
`default_nettype wire
